// [adc_conversion_readout_port.sv]
// Operation
// - Single-word format drives all result bits 11..0
// - Byte format: low byte (bits 7..0) only when address high
// - Read/convert high reads, low starts conversion
// - Stand-alone: a read/convert fall while idle starts conversion
// - Busy flag high throughout a conversion
// - Busy flag falls at end of acquisition, 250 clocks after result is readable
// - Format input: low two bytes, high one word
// - Full conversion gives all 4096 monotonic codes
// - Bipolar results are offset binary codes
// - All-ones code only at top of range
// - Sample taken fixed delay after start edge
// - Address low full cycle, high short cycle
// - Byte format: upper byte (bits 11..4) only when address low
// - Byte format, address high: middle nibble zero
`timescale 1ns/1ps
`include "adc_readout_map.svh"
module adc_conversion_readout_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_enable,
  input wire logic chip_select_n,
  input wire logic read_convert,
  input wire logic fmt_single_word,
  input wire logic byte_address_short_cycle,
  input wire logic [11:0] analog_level,
  output logic [3:0] low_nibble_pins,
  output logic [3:0] low_nibble_oe,
  output logic [3:0] middle_nibble_pins,
  output logic [3:0] middle_nibble_oe,
  output logic [3:0] high_nibble_pins,
  output logic [3:0] high_nibble_oe,
  output logic conversion_busy_flag
);

  localparam int RES = `ADC_RES_BITS;
  localparam int APERTURE_CYCLES = (`ADC_APERTURE_NS * `ADC_CLK_MHZ + 999) / 1000;
  localparam int ACQUIRE_CYCLES = (`ADC_ACQUIRE_NS * `ADC_CLK_MHZ + 999) / 1000;
  localparam int FULL_CONV_CYCLES = RES + 1;

  adc_readout_pkg::conv_state_t state;
  logic [9:0] phase_cnt;
  logic ce_s;
  logic cs_n_s;
  logic rc_s;
  logic fmt_s;
  logic a0_s;
  logic [RES-1:0] level_s;
  logic rc_prev;
  logic convert_prev;
  logic convert_sel;
  logic read_sel;
  logic start_req;
  logic data_avail;
  logic sar_start;
  logic sar_running;
  logic sar_done;
  logic [RES-1:0] sar_code;
  logic [RES-1:0] sample_code;
  logic [RES-1:0] result;
  logic short_latched;
  logic [1:0] ctrl;
  logic [15:0] conv_count;
  logic [RES-1:0] data_q;
  logic [RES-1:0] oe_q;
  logic [RES-1:0] next_data;
  logic [RES-1:0] next_oe;
  logic apb_access;
  logic addr_hit;
  logic [31:0] read_word;

  pin_sync #(
    .WIDTH(RES + 5)
  ) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in({chip_enable, chip_select_n, read_convert, fmt_single_word,
               byte_address_short_cycle, analog_level}),
    .sync_out({ce_s, cs_n_s, rc_s, fmt_s, a0_s, level_s})
  );

  // Front end delivers two's complement when bipolar
  assign sample_code = ctrl[`ADC_CTRL_BIPOLAR] ? (level_s ^ `ADC_MSB_CODE) : level_s;

  assign convert_sel = ce_s & ~cs_n_s & ~rc_s;
  assign start_req = ctrl[`ADC_CTRL_STANDALONE] ? (rc_prev & ~rc_s)
                                                : (convert_sel & ~convert_prev);
  assign read_sel = ce_s & ~cs_n_s & rc_s;
  // Output buffers stay shut from start until the SAR has finished
  assign data_avail = (state == adc_readout_pkg::ST_IDLE) ||
                      (state == adc_readout_pkg::ST_ACQUIRE);
  assign sar_start = (state == adc_readout_pkg::ST_APERTURE) &&
                     (phase_cnt == 10'(APERTURE_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_prev <= 1'b0;
      convert_prev <= 1'b0;
    end else begin
      rc_prev <= rc_s;
      convert_prev <= convert_sel;
    end
  end

  sar_engine #(
    .WIDTH(RES),
    .SHORT_WIDTH(`ADC_SHORT_BITS)
  ) u_sar (
    .clk(pclk),
    .rst_n(presetn),
    .start(sar_start),
    .short_cycle(short_latched),
    .sample(sample_code),
    .running(sar_running),
    .done(sar_done),
    .code(sar_code)
  );

  // Conversion sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= adc_readout_pkg::ST_IDLE;
      phase_cnt <= '0;
      short_latched <= 1'b0;
    end else begin
      case (state)
        adc_readout_pkg::ST_IDLE: begin
          if (start_req) begin
            state <= adc_readout_pkg::ST_APERTURE;
            phase_cnt <= '0;
            short_latched <= a0_s;
          end
        end
        adc_readout_pkg::ST_APERTURE: begin
          if (sar_start) begin
            state <= adc_readout_pkg::ST_CONVERT;
          end else begin
            phase_cnt <= phase_cnt + 10'd1;
          end
        end
        adc_readout_pkg::ST_CONVERT: begin
          if (sar_done) begin
            state <= adc_readout_pkg::ST_ACQUIRE;
            phase_cnt <= '0;
          end
        end
        adc_readout_pkg::ST_ACQUIRE: begin
          // Start requests here are dropped, not queued
          if (phase_cnt == 10'(ACQUIRE_CYCLES - 1)) begin
            state <= adc_readout_pkg::ST_IDLE;
          end else begin
            phase_cnt <= phase_cnt + 10'd1;
          end
        end
        default: begin
          state <= adc_readout_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_busy_flag <= 1'b0;
    end else if ((state == adc_readout_pkg::ST_IDLE) && start_req) begin
      conversion_busy_flag <= 1'b1;
    end else if ((state == adc_readout_pkg::ST_ACQUIRE) &&
                 (phase_cnt == 10'(ACQUIRE_CYCLES - 1))) begin
      conversion_busy_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= '0;
      conv_count <= '0;
    end else if (sar_done) begin
      result <= sar_code;
      conv_count <= conv_count + 16'd1;
    end
  end

  // Three-state data pins, one enable per pin
  always_comb begin
    next_data = '0;
    next_oe = `ADC_OE_NONE;
    if (read_sel && data_avail) begin
      if (fmt_s) begin
        next_data = result;
        next_oe = `ADC_OE_ALL;
      end else if (!a0_s) begin
        next_data = {result[11:4], 4'h0};
        next_oe = `ADC_OE_UPPER_BYTE;
      end else begin
        next_data = {8'h00, result[3:0]};
        next_oe = `ADC_OE_LOW_BYTE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= '0;
      oe_q <= `ADC_OE_NONE;
    end else begin
      data_q <= next_data;
      oe_q <= next_oe;
    end
  end

  assign low_nibble_pins = data_q[3:0];
  assign middle_nibble_pins = data_q[7:4];
  assign high_nibble_pins = data_q[11:8];
  assign low_nibble_oe = oe_q[3:0];
  assign middle_nibble_oe = oe_q[7:4];
  assign high_nibble_oe = oe_q[11:8];

  // APB slave, one wait state so read data comes from a flop
  assign apb_access = psel & penable;

  always_comb begin
    addr_hit = 1'b1;
    read_word = '0;
    case (paddr)
      `ADC_REG_CTRL: begin
        read_word[1:0] = ctrl;
      end
      `ADC_REG_STATUS: begin
        read_word[`ADC_STAT_BUSY] = conversion_busy_flag;
        read_word[`ADC_STAT_SHORT] = short_latched;
        read_word[`ADC_STAT_DATA_AVAIL] = data_avail;
      end
      `ADC_REG_RESULT: begin
        read_word[RES-1:0] = result;
      end
      `ADC_REG_COUNT: begin
        read_word[15:0] = conv_count;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (apb_access && !pready) begin
      pready <= 1'b1;
      pslverr <= ~addr_hit;
      prdata <= pwrite ? 32'h0000_0000 : read_word;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Bipolar mode is applied at the sampling moment, so a change during the aperture hits the current conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `ADC_CTRL_RESET;
    end else if (apb_access && pready && pwrite && (paddr == `ADC_REG_CTRL)) begin
      ctrl <= pwdata[1:0];
    end
  end

  property p_busy_in_conversion;
    @(posedge pclk) disable iff (!presetn)
      (state != adc_readout_pkg::ST_IDLE) |-> conversion_busy_flag;
  endproperty
  a_busy_in_conversion: assert property (p_busy_in_conversion)
    else $error("busy flag low during conversion");

  property p_busy_falls_after_acquire;
    @(posedge pclk) disable iff (!presetn)
      $fell(conversion_busy_flag) |-> $past(state) == adc_readout_pkg::ST_ACQUIRE &&
                                     state == adc_readout_pkg::ST_IDLE;
  endproperty
  a_busy_falls_after_acquire: assert property (p_busy_falls_after_acquire)
    else $error("busy flag fell outside acquisition end");

  property p_ignore_busy_start;
    @(posedge pclk) disable iff (!presetn)
      (state == adc_readout_pkg::ST_CONVERT && start_req && !sar_done) |=>
        state == adc_readout_pkg::ST_CONVERT;
  endproperty
  a_ignore_busy_start: assert property (p_ignore_busy_start)
    else $error("convert request restarted a busy conversion");

  property p_hiz_without_read;
    @(posedge pclk) disable iff (!presetn)
      !(read_sel && data_avail) |=> oe_q == `ADC_OE_NONE;
  endproperty
  a_hiz_without_read: assert property (p_hiz_without_read)
    else $error("data pins driven with no read selected");

  property p_single_word;
    @(posedge pclk) disable iff (!presetn)
      (read_sel && data_avail && fmt_s) |=>
        oe_q == `ADC_OE_ALL && data_q[3:0] == $past(result[3:0]) &&
        data_q == $past(result);
  endproperty
  a_single_word: assert property (p_single_word)
    else $error("single word read wrong");

  property p_upper_byte;
    @(posedge pclk) disable iff (!presetn)
      (read_sel && data_avail && !fmt_s && !a0_s) |=>
        oe_q == `ADC_OE_UPPER_BYTE && data_q[11:4] == $past(result[11:4]);
  endproperty
  a_upper_byte: assert property (p_upper_byte)
    else $error("upper byte read wrong");

  property p_low_byte;
    @(posedge pclk) disable iff (!presetn)
      (read_sel && data_avail && !fmt_s && a0_s) |=>
        oe_q == `ADC_OE_LOW_BYTE && data_q[7:4] == 4'h0 &&
        data_q[3:0] == $past(result[3:0]);
  endproperty
  a_low_byte: assert property (p_low_byte)
    else $error("low byte read wrong");

  property p_aperture_delay;
    @(posedge pclk) disable iff (!presetn)
      $rose(state == adc_readout_pkg::ST_APERTURE) |->
        ##APERTURE_CYCLES state == adc_readout_pkg::ST_CONVERT;
  endproperty
  a_aperture_delay: assert property (p_aperture_delay)
    else $error("sample not taken at aperture delay");

  property p_standalone_start;
    @(posedge pclk) disable iff (!presetn)
      (ctrl[`ADC_CTRL_STANDALONE] && rc_prev && !rc_s &&
       state == adc_readout_pkg::ST_IDLE) |=>
        state == adc_readout_pkg::ST_APERTURE && conversion_busy_flag;
  endproperty
  a_standalone_start: assert property (p_standalone_start)
    else $error("falling read/convert did not start conversion");

  property p_full_code;
    @(posedge pclk) disable iff (!presetn)
      (sar_start && !short_latched) |->
        ##FULL_CONV_CYCLES sar_done ##1 result == $past(sample_code, FULL_CONV_CYCLES + 1);
  endproperty
  a_full_code: assert property (p_full_code)
    else $error("full conversion result mismatch");

  c_full_conv: cover property (@(posedge pclk) disable iff (!presetn)
    sar_done && !short_latched);
  c_short_conv: cover property (@(posedge pclk) disable iff (!presetn)
    sar_done && short_latched);
  c_low_byte_read: cover property (@(posedge pclk) disable iff (!presetn)
    oe_q == `ADC_OE_LOW_BYTE);
  c_start_while_busy: cover property (@(posedge pclk) disable iff (!presetn)
    start_req && state != adc_readout_pkg::ST_IDLE);

endmodule : adc_conversion_readout_port

// [adc_readout_map.svh]
`ifndef ADC_READOUT_MAP_SVH
`define ADC_READOUT_MAP_SVH

`define ADC_RES_BITS 12
`define ADC_SHORT_BITS 8
`define ADC_CLK_MHZ 250
`define ADC_APERTURE_NS 20
`define ADC_ACQUIRE_NS 1000

`define ADC_MSB_CODE 12'h800
`define ADC_OE_NONE 12'h000
`define ADC_OE_ALL 12'hFFF
`define ADC_OE_UPPER_BYTE 12'hFF0
`define ADC_OE_LOW_BYTE 12'h0FF

`define ADC_REG_CTRL 12'h000
`define ADC_REG_STATUS 12'h004
`define ADC_REG_RESULT 12'h008
`define ADC_REG_COUNT 12'h00C

`define ADC_CTRL_BIPOLAR 0
`define ADC_CTRL_STANDALONE 1
`define ADC_CTRL_RESET 2'h0

`define ADC_STAT_BUSY 0
`define ADC_STAT_SHORT 1
`define ADC_STAT_DATA_AVAIL 2

`endif

// [adc_readout_pkg.sv]
package adc_readout_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_APERTURE,
    ST_CONVERT,
    ST_ACQUIRE
  } conv_state_t;

endpackage : adc_readout_pkg

// [pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : pin_sync

// [sar_engine.sv]
`timescale 1ns/1ps
module sar_engine #(
  parameter int WIDTH = 12,
  parameter int SHORT_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic short_cycle,
  input wire logic [WIDTH-1:0] sample,
  output logic running,
  output logic done,
  output logic [WIDTH-1:0] code
);

  localparam logic [WIDTH-1:0] FIRST_BIT = WIDTH'(1) << (WIDTH - 1);
  localparam logic [WIDTH-1:0] SHORT_LAST = WIDTH'(1) << (WIDTH - SHORT_WIDTH);
  localparam logic [WIDTH-1:0] FULL_LAST = WIDTH'(1);

  logic [WIDTH-1:0] bit_mask;
  logic [WIDTH-1:0] last_mask;
  logic [WIDTH-1:0] trial;
  logic [WIDTH-1:0] held;

  assign trial = code | bit_mask;

  // One bit decided per clock, MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
      done <= 1'b0;
      code <= '0;
      bit_mask <= '0;
      last_mask <= '0;
      held <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        running <= 1'b1;
        code <= '0;
        bit_mask <= FIRST_BIT;
        // Input frozen at start so later moves cannot leak into low bits
        held <= sample;
        last_mask <= short_cycle ? SHORT_LAST : FULL_LAST;
      end else if (running) begin
        // Keep bit while trial stays at or under the held input
        if (trial <= held) begin
          code <= trial;
        end
        if (bit_mask == last_mask) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          bit_mask <= bit_mask >> 1;
        end
      end
    end
  end

endmodule : sar_engine

// [host_port_model.sv]
`timescale 1ns/1ps
module host_port_model (
  input wire logic pclk,
  output logic chip_enable,
  output logic chip_select_n,
  output logic read_convert,
  output logic fmt_single_word,
  output logic byte_address_short_cycle,
  input wire logic [3:0] low_nibble_pins,
  input wire logic [3:0] low_nibble_oe,
  input wire logic [3:0] middle_nibble_pins,
  input wire logic [3:0] middle_nibble_oe,
  input wire logic [3:0] high_nibble_pins,
  input wire logic [3:0] high_nibble_oe,
  output logic [11:0] bus_oe,
  output logic [11:0] bus_value,
  output logic bus_valid
);
  logic [11:0] float_pat;
  logic [11:0] oe;
  logic [11:0] data;
  assign oe = {high_nibble_oe, middle_nibble_oe, low_nibble_oe};
  assign data = {high_nibble_pins, middle_nibble_pins, low_nibble_pins};
  initial begin
    chip_enable = 1'b0;
    chip_select_n = 1'b1;
    read_convert = 1'b1;
    fmt_single_word = 1'b1;
    byte_address_short_cycle = 1'b0;
    bus_oe = 12'h000;
    bus_value = 12'h000;
    bus_valid = 1'b0;
    float_pat = 12'hA5A;
  end
  // Released lines never keep the last driven level
  always @(posedge pclk) float_pat <= ~float_pat;
  task automatic convert(input logic a0);
    @(posedge pclk);
    read_convert <= 1'b0;
    byte_address_short_cycle <= a0;
    @(posedge pclk);
    chip_enable <= 1'b1;
    chip_select_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chip_enable <= 1'b0;
    chip_select_n <= 1'b1;
  endtask : convert
  task automatic pulse();
    @(posedge pclk);
    read_convert <= 1'b1;
    repeat (3) @(posedge pclk);
    read_convert <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse
  task automatic sample(input logic sel, input logic fmt, input logic a0);
    @(posedge pclk);
    chip_enable <= sel;
    chip_select_n <= !sel;
    read_convert <= 1'b1;
    fmt_single_word <= fmt;
    byte_address_short_cycle <= a0;
    repeat (6) @(posedge pclk);
    bus_oe <= oe;
    bus_value <= (oe & data) | (~oe & float_pat);
    bus_valid <= 1'b1;
    @(posedge pclk);
    bus_valid <= 1'b0;
    chip_enable <= 1'b0;
    chip_select_n <= 1'b1;
  endtask : sample
endmodule : host_port_model

// [test_adc_conversion_readout_port.sv]
`timescale 1ns/1ps
`include "adc_readout_map.svh"
module test_adc_conversion_readout_port;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic chip_enable, chip_select_n, read_convert, fmt_single_word, byte_address_short_cycle;
  logic [11:0] analog_level, bus_oe, bus_value, r;
  logic [3:0] lo_d, lo_oe, mid_d, mid_oe, hi_d, hi_oe;
  logic conversion_busy_flag, bus_valid;
  logic [11:0] lv [5];
  int failures, check_count, run_len, exp_len, seed;
  logic [32:0] apb_q [$];
  logic [23:0] pin_q [$];
  int len_q [$];
  always #2 pclk = ~pclk;
  adc_conversion_readout_port i_adc_conversion_readout_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_enable(chip_enable), .chip_select_n(chip_select_n), .read_convert(read_convert),
    .fmt_single_word(fmt_single_word), .byte_address_short_cycle(byte_address_short_cycle),
    .analog_level(analog_level), .low_nibble_pins(lo_d), .low_nibble_oe(lo_oe),
    .middle_nibble_pins(mid_d), .middle_nibble_oe(mid_oe), .high_nibble_pins(hi_d),
    .high_nibble_oe(hi_oe), .conversion_busy_flag(conversion_busy_flag));
  host_port_model i_host_port_model (
    .pclk(pclk), .chip_enable(chip_enable), .chip_select_n(chip_select_n),
    .read_convert(read_convert), .fmt_single_word(fmt_single_word),
    .byte_address_short_cycle(byte_address_short_cycle), .low_nibble_pins(lo_d),
    .low_nibble_oe(lo_oe), .middle_nibble_pins(mid_d), .middle_nibble_oe(mid_oe),
    .high_nibble_pins(hi_d), .high_nibble_oe(hi_oe), .bus_oe(bus_oe),
    .bus_value(bus_value), .bus_valid(bus_valid));
  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    apb_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (conversion_busy_flag !== lvl && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk("busy_level", 33'(lvl), 33'(conversion_busy_flag));
  endtask : wait_busy
  task automatic rd(input logic sel, input logic fmt, input logic a0, input logic [23:0] e);
    pin_q.push_back(e);
    i_host_port_model.sample(sel, fmt, a0);
  endtask : rd
  task automatic conv(input logic [11:0] lvl, input logic a0, input logic sa,
                      input logic [11:0] code);
    analog_level <= lvl;
    len_q.push_back(a0 ? 264 : 268);
    if (sa) i_host_port_model.pulse();
    else i_host_port_model.convert(a0);
    wait_busy(1'b1);
    repeat (12) @(posedge pclk);
    // Level moves after the sampling moment and must not leak in
    analog_level <= ~lvl;
    if (sa) i_host_port_model.pulse();
    wait_busy(1'b0);
    repeat (20) @(posedge pclk);
    chk("busy_after", 33'h0, 33'(conversion_busy_flag));
    rd(1'b1, 1'b1, 1'b0, {12'hFFF, code});
    rd(1'b1, 1'b0, 1'b0, {12'hFF0, code & 12'hFF0});
    rd(1'b1, 1'b0, 1'b1, {12'h0FF, 8'h00, code[3:0]});
    rd(1'b0, 1'b1, 1'b0, 24'h000000);
    apb(1'b0, `ADC_REG_RESULT, 32'h0, {21'h0, code});
    apb(1'b0, `ADC_REG_STATUS, 32'h0, {30'h0, 1'b1, a0, 1'b0});
    chk("busy_read", 33'h0, 33'(conversion_busy_flag));
  endtask : conv
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
      chk("apb", apb_q.size() ? apb_q.pop_front() : 33'h0, {pslverr, prdata});
    if (bus_valid === 1'b1)
      chk("pins", 33'(pin_q.size() ? pin_q.pop_front() : 24'h0), 33'({bus_oe, bus_value & bus_oe}));
    if (conversion_busy_flag === 1'b1) run_len <= run_len + 1;
    else if (run_len != 0) begin
      exp_len = len_q.size() ? len_q.pop_front() : 0;
      chk("busy_len", 33'(exp_len), 33'(run_len));
      run_len <= 0;
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    $display("mismatch watchdog expected done seen timeout");
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    analog_level = 12'h000;
    failures = 0;
    check_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    seed = $urandom(32'h7123);
    @(posedge pclk);
    chk("oe_reset", 33'h0, 33'({hi_oe, mid_oe, lo_oe}));
    apb(1'b0, `ADC_REG_CTRL, 32'h0, 33'h0);
    apb(1'b1, `ADC_REG_CTRL, 32'h3, 33'h0);
    apb(1'b0, `ADC_REG_CTRL, 32'h0, 33'h3);
    apb(1'b0, 12'h010, 32'h0, 33'h100000000);
    apb(1'b1, `ADC_REG_STATUS, 32'hFFFFFFFF, 33'h0);
    apb(1'b1, `ADC_REG_CTRL, 32'h0, 33'h0);
    lv = '{12'hFFF, 12'hFFE, 12'($urandom()), 12'($urandom()), 12'($urandom())};
    foreach (lv[i]) conv(lv[i], i == 4, 1'b0, (i == 4) ? lv[i] & 12'hFF0 : lv[i]);
    apb(1'b1, `ADC_REG_CTRL, 32'h1, 33'h0);
    conv(12'h000, 1'b0, 1'b0, 12'h800);
    conv(12'hFFF, 1'b0, 1'b0, 12'h7FF);
    apb(1'b1, `ADC_REG_CTRL, 32'h2, 33'h0);
    r = 12'($urandom());
    conv(r, 1'b0, 1'b1, r);
    apb(1'b0, `ADC_REG_COUNT, 32'h0, 33'h8);
    wrap_up();
  end
endmodule : test_adc_conversion_readout_port
